// ### acq_pkg.sv
package acq_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] FIFO_STATUS_OFFSET  = 8'h18;  // Read side of the shared word
  localparam logic [7:0] FIFO_CONTROL_OFFSET = 8'h18;  // Write side of the shared word
  localparam logic [7:0] SAMPLING_ARM_OFFSET = 8'h1C;  // Acquisition enable word
  localparam logic [7:0] CLOCK_SELECT_OFFSET = 8'h20;  // Sample clock select word

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CAN_ACCEPT_POS   = 0;  // Status: buffer not full
  localparam int HALF_LEVEL_POS   = 1;  // Status: buffer at least half full
  localparam int HAS_SAMPLES_POS  = 2;  // Status: buffer not empty
  localparam int COUNT_ZERO_POS   = 3;  // Status: post counter at zero
  localparam int TRIGGER_SEEN_POS = 4;  // Status: trigger detected
  localparam int ACTIVE_POS       = 5;  // Status: sampling in progress
  localparam int FLUSH_POS        = 0;  // Control: empty the buffer
  localparam int TRIG_CLEAR_POS   = 1;  // Control: clear trigger flag
  localparam int ARM_POS          = 0;  // Arm word: enable bit
  localparam int FAST_POS         = 0;  // Clock word: source faster than bus
  localparam int CODE_LSB_POS     = 1;  // Clock word: source code low bit
  localparam int CODE_MSB_POS     = 2;  // Clock word: source code high bit

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic        ARM_RESET  = 1'b0;   // Disarmed
  localparam logic [1:0]  CODE_RESET = 2'h0;   // Internal source
  localparam logic        FAST_RESET = 1'b0;   // Slow source hint
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // ****************************************
  // Sizes and timing
  // ****************************************
  localparam int SAMPLE_W      = 32;     // One packed sample word
  localparam int BUFFER_DEPTH  = 32768;  // Main sample buffer
  localparam int STAGE_DEPTH   = 8;      // Output stage toward the transfer engine
  localparam int CLOCK_MHZ     = 100;    // Register clock rate
  localparam int INT_SRC_MHZ   = 40;     // Internal source clock rate
  localparam logic [6:0] ACC_STEP = 7'(INT_SRC_MHZ);  // Accumulator step per cycle
  localparam logic [6:0] ACC_MOD  = 7'(CLOCK_MHZ);    // Accumulator wrap
  localparam logic [15:0] DIVISOR_MIN = 16'h0002;     // Smallest usable divisor

  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'h0,  // On-board source
    SRC_SINE     = 2'h1,  // External sine-wave clock
    SRC_DIGITAL  = 2'h2,  // External digital clock
    SRC_ILLEGAL  = 2'h3   // No sampling
  } source_code_e;

  typedef enum logic [2:0] {
    MODE_SOFTWARE = 3'h0,
    MODE_POST     = 3'h1,
    MODE_PRE      = 3'h2,
    MODE_DELAY    = 3'h3,
    MODE_MIDDLE   = 3'h4
  } trigger_mode_e;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,  // Disarmed
    ST_WAIT  = 5'h02,  // Armed, waiting for trigger
    ST_DELAY = 5'h04,  // Counting down before sampling
    ST_RUN   = 5'h08,  // Taking samples
    ST_DONE  = 5'h10   // Finished, waiting for disarm
  } acq_state_e;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [7:0]  addr;   // Byte offset of the word
    logic        wr;     // Write strobe, one cycle
    logic        rd;     // Read strobe, one cycle
    logic [31:0] wdata;  // Write data
  } reg_req_s;

  typedef struct packed {
    logic [15:0] divisor;      // Divider value, bit 0 ignored
    logic [15:0] preload;      // Post counter preload
    logic        preload_load; // Preload register written, one cycle
    logic [2:0]  mode;         // Trigger mode code
  } acq_cfg_s;

endpackage

// ### sample_fifo.sv
`timescale 1ns/1ns
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [$clog2(DEPTH)+1:0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];      // Storage
  logic [AW-1:0]    wr_ptr_reg;       // Write pointer
  logic [AW-1:0]    rd_ptr_reg;       // Read pointer
  logic [AW:0]      count_reg;        // Words held in storage
  logic             out_valid_reg;    // Head register full
  logic [WIDTH-1:0] out_data_reg;     // Head register
  logic             push;             // Word enters storage
  logic             load;             // Word moves to head register

  // ****************************************
  // Handshake
  // ****************************************
  assign in_ready  = (count_reg != (AW + 1)'(DEPTH));
  assign push      = in_valid && in_ready && !flush;
  assign load      = (count_reg != '0) && (!out_valid_reg || out_ready) && !flush;
  assign out_valid = out_valid_reg;
  assign out_data  = out_data_reg;
  assign level     = (AW + 2)'(count_reg) + (AW + 2)'(out_valid_reg);

  // Storage write
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clock)
  begin
    if (reset || flush)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (load)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(load);
    end
  end

  // Registered read into the head
  always_ff @(posedge clock)
  begin
    if (reset || flush)
    begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end
    else if (load)
    begin
      out_valid_reg <= 1'b1;
      out_data_reg  <= mem[rd_ptr_reg];
    end
    else if (out_ready)
    begin
      out_valid_reg <= 1'b0;
    end
  end
endmodule // sample_fifo

// ### acq_fifo_clock_control.sv
`timescale 1ns/1ns
// Overview of operation
// R1: Status bit 0 shows buffer not full
// R2: Status bit 1 shows buffer half full
// R3: Status bit 2 shows buffer not empty
// R4: Status bit 3 shows post counter zero
// R5: Status bit 4 shows trigger detected
// R6: Status bit 5 shows sampling in progress
// R7: Offset 18h reads status, writes control
// R8: Control bit 0 empties whole buffer
// R9: Control bit 1 clears trigger flag
// R10: Control bits 2 to 31 ignored
// R11: Offset 1Ch bit 0 arms sampling
// R12: Offset 20h bits 2..1 choose source
// R13: Bit 0 hints source faster than bus
// R14: External source uses the same divider
// R15: Samples buffered in 32K-sample memory
// R16: Conversion starts only after trigger condition; pre and middle modes start sampling on arm
// R17: Samples leave by streaming transfer port
// R18: Post counter 16-bit, loads, decrements, halts
// R19: Divisor even, at least two
// R20: Pre-trigger sampling stops on trigger
// R21: Zero strobes inert; illegal source stops sampling
module acq_fifo_clock_control (
  input  wire logic                    clock,
  input  wire logic                    reset,
  input  wire acq_pkg::reg_req_s       reg_req,
  output logic [31:0]                  reg_rdata,
  output logic                         reg_rvalid,
  input  wire acq_pkg::acq_cfg_s       acq_cfg,
  input  wire logic                    trigger_detect,
  input  wire logic                    ext_sine_clock,
  input  wire logic                    ext_digital_clock,
  input  wire logic [acq_pkg::SAMPLE_W-1:0] adc_sample,
  output logic                         dma_valid,
  input  wire logic                    dma_ready,
  output logic [acq_pkg::SAMPLE_W-1:0] dma_data,
  output logic                         sample_tick,
  output logic                         sampling_active
);
  import acq_pkg::*;

  localparam int BUF_LW   = $clog2(BUFFER_DEPTH) + 2;  // Main level width

  // ****************************************
  // Declarations
  // ****************************************
  logic                sampling_arm_reg;     // Arm bit
  logic [1:0]          source_clock_code;    // Selected source
  logic                source_fast_reg;      // Source faster than bus
  logic                buffer_flush;         // Flush strobe
  logic                trigger_seen_clear;   // Trigger flag clear strobe
  logic                trigger_seen_reg;     // Trigger detected flag
  logic                trigger_seen_set;     // Trigger detected event
  logic [15:0]         post_count_reg;       // Post trigger down counter
  logic                post_count_zero;      // Counter at zero
  acq_state_e          state_reg;            // Acquisition state
  acq_state_e          state_next;           // Next acquisition state
  logic [1:0]          sine_sync_reg;        // Sine clock synchroniser
  logic [1:0]          digital_sync_reg;     // Digital clock synchroniser
  logic                ext_level;            // Selected synchronised level
  logic                ext_last_reg;         // Previous level for edge detect
  logic [6:0]          int_acc_reg;          // Internal source accumulator
  logic                int_tick;             // Internal source tick
  logic                ext_tick;             // External source tick
  logic                source_tick;          // Selected source tick
  logic [16:0]         div_count_reg;        // Divider count
  logic [16:0]         div_target;           // Divider terminal count
  logic [15:0]         divisor_even;         // Divisor with bit 0 cleared
  logic                mode_legal;           // Trigger mode code is usable
  logic                sample_push;          // Sample written to buffer
  logic                buf_ready;            // Buffer not full
  logic                buf_out_valid;        // Buffer head valid
  logic [SAMPLE_W-1:0] buf_out_data;         // Buffer head word
  logic [BUF_LW-1:0]   buf_level;            // Words in buffer
  logic                stage_ready;          // Stage can accept
  logic                buffer_can_accept;    // Status bit
  logic                buffer_half_level;    // Status bit
  logic                buffer_has_samples;   // Status bit

  // Write decode helper
  function automatic logic write_hit(input reg_req_s req, input logic [7:0] offset);
    write_hit = req.wr && (req.addr == offset);
  endfunction

  // ****************************************
  // Register writes
  // ****************************************

  // Control strobes, ones only act
  always_comb
  begin
    buffer_flush       = write_hit(reg_req, FIFO_CONTROL_OFFSET) && reg_req.wdata[FLUSH_POS];      // see R8 R10 R21
    trigger_seen_clear = write_hit(reg_req, FIFO_CONTROL_OFFSET) && reg_req.wdata[TRIG_CLEAR_POS]; // see R9 R21
  end

  // Arm word
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sampling_arm_reg <= ARM_RESET;
    end
    else if (write_hit(reg_req, SAMPLING_ARM_OFFSET))
    begin
      sampling_arm_reg <= reg_req.wdata[ARM_POS];  // see R11
    end
  end

  // Clock select word
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      source_clock_code <= CODE_RESET;
      source_fast_reg   <= FAST_RESET;
    end
    else if (write_hit(reg_req, CLOCK_SELECT_OFFSET))
    begin
      source_clock_code <= reg_req.wdata[CODE_MSB_POS:CODE_LSB_POS];  // see R12
      source_fast_reg   <= reg_req.wdata[FAST_POS];                   // see R13
    end
  end

  // ****************************************
  // Register reads
  // ****************************************

  // Status word, others read zero
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd && (reg_req.addr == FIFO_STATUS_OFFSET))
      begin
        reg_rdata                   <= 32'h0000_0000;  // see R7
        reg_rdata[CAN_ACCEPT_POS]   <= buffer_can_accept;
        reg_rdata[HALF_LEVEL_POS]   <= buffer_half_level;
        reg_rdata[HAS_SAMPLES_POS]  <= buffer_has_samples;
        reg_rdata[COUNT_ZERO_POS]   <= post_count_zero;
        reg_rdata[TRIGGER_SEEN_POS] <= trigger_seen_reg;
        reg_rdata[ACTIVE_POS]       <= sampling_active;
      end
      else if (reg_req.rd)
      begin
        reg_rdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // Source clocks
  // ****************************************

  // Two-stage synchronisers for the pins
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sine_sync_reg    <= 2'h0;
      digital_sync_reg <= 2'h0;
    end
    else
    begin
      sine_sync_reg    <= {sine_sync_reg[0], ext_sine_clock};
      digital_sync_reg <= {digital_sync_reg[0], ext_digital_clock};
    end
  end

  // Pick the synchronised external level
  always_comb
  begin
    ext_level = (source_clock_code == SRC_SINE) ? sine_sync_reg[1] : digital_sync_reg[1];
  end

  // Edge history of the selected level
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ext_last_reg <= 1'b0;
    end
    else
    begin
      ext_last_reg <= ext_level;
    end
  end

  // Fast hint counts both edges, slow only rising
  always_comb
  begin
    if (source_fast_reg)
    begin
      ext_tick = ext_level ^ ext_last_reg;  // see R13
    end
    else
    begin
      ext_tick = ext_level && !ext_last_reg;
    end
  end

  // Internal source as a rate accumulator
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      int_acc_reg <= 7'h00;
    end
    else if (int_acc_reg + ACC_STEP >= ACC_MOD)
    begin
      int_acc_reg <= int_acc_reg + ACC_STEP - ACC_MOD;
    end
    else
    begin
      int_acc_reg <= int_acc_reg + ACC_STEP;
    end
  end

  assign int_tick = (int_acc_reg + ACC_STEP >= ACC_MOD);

  // Source mux, illegal code gives no ticks
  always_comb
  begin
    case (source_clock_code)
      SRC_INTERNAL: source_tick = int_tick;
      SRC_SINE:     source_tick = ext_tick;  // see R14
      SRC_DIGITAL:  source_tick = ext_tick;  // see R14
      default:      source_tick = 1'b0;      // see R21
    endcase
  end

  // ****************************************
  // Divider
  // ****************************************

  // Even divisor, never below two
  always_comb
  begin
    divisor_even = {acq_cfg.divisor[15:1], 1'b0};  // see R19
    if (divisor_even < DIVISOR_MIN)
    begin
      divisor_even = DIVISOR_MIN;
    end
    // Both-edge counting sees two ticks per source period
    div_target = source_fast_reg ? {divisor_even, 1'b0} : {1'b0, divisor_even};
  end

  // Count source ticks into sample ticks
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      div_count_reg <= 17'h00000;
    end
    else if (source_tick)
    begin
      if (div_count_reg + 17'h00001 >= div_target)
      begin
        div_count_reg <= 17'h00000;
      end
      else
      begin
        div_count_reg <= div_count_reg + 17'h00001;
      end
    end
  end

  assign sample_tick = source_tick && (div_count_reg + 17'h00001 >= div_target);  // see R14 R19

  // ****************************************
  // Trigger flag and post counter
  // ****************************************

  // Trigger taken only while armed and listening
  always_comb
  begin
    trigger_seen_set = 1'b0;
    if (state_reg == ST_WAIT)
    begin
      trigger_seen_set = trigger_detect;
    end
    else if ((state_reg == ST_RUN) && !trigger_seen_reg &&
             ((acq_cfg.mode == MODE_PRE) || (acq_cfg.mode == MODE_MIDDLE)))
    begin
      trigger_seen_set = trigger_detect;
    end
    else if ((state_reg == ST_IDLE) && (state_next == ST_RUN) && (acq_cfg.mode == MODE_SOFTWARE))
    begin
      trigger_seen_set = 1'b1;
    end
  end

  // Set wins over clear
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      trigger_seen_reg <= 1'b0;
    end
    else if (trigger_seen_set)
    begin
      trigger_seen_reg <= 1'b1;  // see R5
    end
    else if (trigger_seen_clear)
    begin
      trigger_seen_reg <= 1'b0;  // see R9
    end
  end

  // Load on preload write, count after trigger, stop at zero
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      post_count_reg <= COUNT_RESET;
    end
    else if (acq_cfg.preload_load)
    begin
      post_count_reg <= acq_cfg.preload;  // see R18
    end
    else if (sample_tick && trigger_seen_reg && (state_reg != ST_IDLE) && !post_count_zero)
    begin
      post_count_reg <= post_count_reg - 16'h0001;  // see R18
    end
  end

  assign post_count_zero = (post_count_reg == 16'h0000);  // see R4

  // ****************************************
  // Acquisition sequence
  // ****************************************

  assign mode_legal = (acq_cfg.mode <= MODE_MIDDLE);

  // Next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (sampling_arm_reg && mode_legal && (source_clock_code != SRC_ILLEGAL))  // see R21
        begin
          case (acq_cfg.mode)
            MODE_PRE:    state_next = ST_RUN;   // see R20
            MODE_MIDDLE: state_next = ST_RUN;
            MODE_POST:   state_next = ST_WAIT;  // see R16
            MODE_DELAY:  state_next = ST_WAIT;
            default:     state_next = ST_RUN;   // Software trigger fires on arm
          endcase
        end
      end
      ST_WAIT:
      begin
        if (trigger_detect)
        begin
          state_next = (acq_cfg.mode == MODE_DELAY) ? ST_DELAY : ST_RUN;  // see R16
        end
      end
      ST_DELAY:
      begin
        if (post_count_zero)
        begin
          state_next = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if ((acq_cfg.mode == MODE_PRE) && trigger_detect)
        begin
          state_next = ST_DONE;  // see R20
        end
        else if ((acq_cfg.mode == MODE_MIDDLE) && trigger_seen_reg && post_count_zero)
        begin
          state_next = ST_DONE;
        end
      end
      ST_DONE:
      begin
        state_next = ST_DONE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
    if (!sampling_arm_reg || (source_clock_code == SRC_ILLEGAL))
    begin
      state_next = ST_IDLE;  // see R11 R21
    end
  end

  // State register
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign sampling_active = (state_reg == ST_RUN);  // see R6

  // ****************************************
  // Sample path
  // ****************************************

  assign sample_push = sample_tick && sampling_active;  // see R16

  // Main sample buffer
  sample_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (BUFFER_DEPTH)
  ) sample_buffer (
    .clock     (clock),
    .reset     (reset),
    .flush     (buffer_flush),  // see R8
    .in_valid  (sample_push),   // see R15
    .in_ready  (buf_ready),
    .in_data   (adc_sample),
    .out_valid (buf_out_valid),
    .out_ready (stage_ready),
    .out_data  (buf_out_data),
    .level     (buf_level)
  );

  // Output stage toward the transfer engine
  sample_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (STAGE_DEPTH)
  ) dma_stage (
    .clock     (clock),
    .reset     (reset),
    .flush     (buffer_flush),
    .in_valid  (buf_out_valid),
    .in_ready  (stage_ready),
    .in_data   (buf_out_data),
    .out_valid (dma_valid),     // see R17
    .out_ready (dma_ready),
    .out_data  (dma_data),
    .level     ()
  );

  // Flags over the main buffer only
  always_comb
  begin
    buffer_can_accept  = buf_ready;                                          // see R1
    buffer_half_level  = (buf_level >= BUF_LW'(BUFFER_DEPTH / 2));           // see R2
    buffer_has_samples = (buf_level != '0);                                  // see R3
  end
endmodule // acq_fifo_clock_control

// ### dma_sink_model.sv
`timescale 1ns/1ns
// ****************************************
// Host memory side of the sample stream
// ****************************************
module dma_sink_model (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        stall,
  input  wire logic        dma_valid,
  input  wire logic [31:0] dma_data,
  output logic             dma_ready,
  output int               words
);
  // Accepts every offered word unless told to stall
  assign dma_ready = !stall;
  // Counts words moved to host memory
  always_ff @(posedge clock)
  begin
    if (reset)
      words <= 0;
    else if (dma_valid && dma_ready)
      words <= words + 1;
  end
endmodule // dma_sink_model

// ### acq_fifo_clock_control_assertions.sv
`timescale 1ns/1ns
module acq_checker (
  input wire logic              clock,
  input wire logic              reset,
  input wire acq_pkg::reg_req_s reg_req,
  input wire logic [31:0]       reg_rdata,
  input wire logic              reg_rvalid,
  input wire logic              dma_valid,
  input wire logic              dma_ready,
  input wire logic [31:0]       dma_data,
  input wire logic              sampling_active
);
  import acq_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Offset of the last request, for judging answers
  logic [7:0] last_addr;
  always_ff @(posedge clock)
  begin
    last_addr <= reg_req.addr;
  end
  wire flush_wr = reg_req.wr && reg_req.addr == FIFO_CONTROL_OFFSET && reg_req.wdata[FLUSH_POS];
  wire stat_ans = reg_rvalid && last_addr == FIFO_STATUS_OFFSET;
  chk_rvalid_after_rd: assert property (reg_req.rd |=> reg_rvalid) else $error("no answer to read");
  chk_rvalid_only_rd: assert property (reg_rvalid |-> $past(reg_req.rd)) else $error("stray answer");
  chk_status_upper_zero: assert property (stat_ans |-> reg_rdata[31:6] == 26'h0) else $error("upper bits set");
  chk_other_reads_zero: assert property (reg_rvalid && !stat_ans |-> reg_rdata == 32'h0) else $error("nonzero");
  chk_active_status: assert property (stat_ans |-> reg_rdata[5] == $past(sampling_active))
    else $error("active flag wrong");
  chk_level_flags: assert property (stat_ans |-> reg_rdata[2] || (!reg_rdata[1] && reg_rdata[0]))
    else $error("level flags disagree");
  chk_dma_hold: assert property (dma_valid && !dma_ready && !flush_wr |=> dma_valid && $stable(dma_data))
    else $error("stream word dropped");
  chk_flush_drops: assert property (flush_wr |=> !dma_valid) else $error("flush left data");
  cov_status_read: cover property (stat_ans);
  cov_stream_word: cover property (dma_valid && dma_ready);
  cov_active_rise: cover property ($rose(sampling_active));
endmodule // acq_checker
bind acq_fifo_clock_control acq_checker i_acq_checker (.clock(clock), .reset(reset), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .dma_valid(dma_valid), .dma_ready(dma_ready),
  .dma_data(dma_data), .sampling_active(sampling_active));

// ### acq_fifo_clock_control_test.sv
`timescale 1ns/1ns
`define CHK(n, e, g) num_checks++; if ((g) !== (e)) begin $display("MISMATCH %s exp %0h got %0h", n, e, g); miscompares++; end
module acq_fifo_clock_control_test;
  import acq_pkg::*;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  reg_req_s    reg_req = '0;
  acq_cfg_s    acq_cfg = '{16'h0002, 16'h0000, 1'b0, 3'h0};
  logic        trigger_detect = 1'b0;
  logic        stall = 1'b1;
  logic [31:0] reg_rdata;
  logic        reg_rvalid;
  logic        dma_valid;
  logic        dma_ready;
  logic [31:0] dma_data;
  logic [31:0] rdat;
  logic        sample_tick;
  logic        ext_clock = 1'b0;  // External digital source pin
  int          ticks = 0;         // Sample ticks seen so far
  int          tick_base;         // Tick count at window start
  int          words;
  int          miscompares = 0;
  int          num_checks = 0;
  always #5 clock = ~clock;
  // External source, period of four bus cycles
  always
  begin
    repeat (2) @(posedge clock);
    #1 ext_clock = ~ext_clock;
  end
  // Counts divided sample ticks
  always @(posedge clock)
    if (sample_tick) ticks++;
  acq_fifo_clock_control i_acq_fifo_clock_control (.clock(clock), .reset(reset), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .acq_cfg(acq_cfg), .trigger_detect(trigger_detect),
    .ext_sine_clock(1'b0), .ext_digital_clock(ext_clock), .adc_sample(32'h0000A5A5), .dma_valid(dma_valid),
    .dma_ready(dma_ready), .dma_data(dma_data), .sample_tick(sample_tick), .sampling_active());
  dma_sink_model i_dma_sink_model (.clock(clock), .reset(reset), .stall(stall), .dma_valid(dma_valid),
    .dma_data(dma_data), .dma_ready(dma_ready), .words(words));
  // ****************************************
  // Bus cycles
  // ****************************************
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock) #1 reg_req = '{a, 1'b1, 1'b0, d};
    @(posedge clock) #1 reg_req.wr = 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock) #1 reg_req = '{a, 1'b0, 1'b1, 32'h0};
    @(posedge clock) #1 reg_req.rd = 1'b0;
    @(posedge clock) #1 rdat = reg_rdata;
  endtask
  // Masked status compare
  task st(input logic [5:0] m, input logic [5:0] e);
    rd(FIFO_STATUS_OFFSET);
    `CHK("status", e, rdat[5:0] & m)
  endtask
  task pulse;
    @(posedge clock) #1 trigger_detect = 1'b1;
    @(posedge clock) #1 trigger_detect = 1'b0;
  endtask
  task idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    st(6'h3F, 6'h09);
  endtask
  task t_unmapped;
    rd(SAMPLING_ARM_OFFSET);
    `CHK("arm read", 32'h0, rdat)
    rd(8'h44);
    `CHK("hole read", 32'h0, rdat)
  endtask
  task t_acquire;
    wr(CLOCK_SELECT_OFFSET, 32'h0);
    wr(SAMPLING_ARM_OFFSET, 32'h1);
    tick_base = ticks;
    idle(100);
    `CHK("int ticks", 20, ticks - tick_base)
    st(6'h34, 6'h34);
    `CHK("dma data", 32'h0000A5A5, dma_data)
    wr(FIFO_CONTROL_OFFSET, 32'hFFFFFFFC);
    st(6'h04, 6'h04);
    stall = 1'b0;
    idle(60);
    `CHK("words", 1'b1, words > 0)
    wr(SAMPLING_ARM_OFFSET, 32'h0);
    st(6'h20, 6'h00);
    wr(FIFO_CONTROL_OFFSET, 32'h3);
    st(6'h15, 6'h01);
    `CHK("dma valid", 1'b0, dma_valid)
  endtask
  task t_post;
    acq_cfg.mode = 3'h1;
    wr(SAMPLING_ARM_OFFSET, 32'h1);
    idle(20);
    st(6'h30, 6'h00);
    pulse;
    idle(20);
    st(6'h30, 6'h30);
    wr(FIFO_CONTROL_OFFSET, 32'h2);
    st(6'h10, 6'h00);
    wr(SAMPLING_ARM_OFFSET, 32'h0);
  endtask
  task t_pre(input logic [2:0] m);
    acq_cfg.mode = m;
    wr(FIFO_CONTROL_OFFSET, 32'h2);
    wr(SAMPLING_ARM_OFFSET, 32'h1);
    idle(20);
    st(6'h20, 6'h20);
    pulse;
    idle(5);
    st(6'h20, 6'h00);
    wr(SAMPLING_ARM_OFFSET, 32'h0);
  endtask
  // Counter loads, runs after trigger, then sampling starts
  task t_delay;
    wr(FIFO_CONTROL_OFFSET, 32'h2);
    acq_cfg = '{16'h0002, 16'h0003, 1'b1, 3'h3};
    idle(1);
    acq_cfg.preload_load = 1'b0;
    wr(SAMPLING_ARM_OFFSET, 32'h1);
    idle(20);
    st(6'h38, 6'h00);
    pulse;
    st(6'h38, 6'h10);
    idle(20);
    st(6'h28, 6'h28);
    wr(SAMPLING_ARM_OFFSET, 32'h0);
  endtask
  // Digital source, slow then fast hint, same sample rate
  task t_external;
    for (int f = 4; f < 6; f++)
    begin
      wr(CLOCK_SELECT_OFFSET, 32'(f));
      idle(20);
      tick_base = ticks;
      idle(80);
      `CHK("ext ticks", 10, ticks - tick_base)
    end
  endtask
  task t_illegal;
    acq_cfg.mode = 3'h0;
    wr(CLOCK_SELECT_OFFSET, 32'h6);
    wr(SAMPLING_ARM_OFFSET, 32'h1);
    tick_base = ticks;
    idle(20);
    st(6'h20, 6'h00);
    `CHK("illegal ticks", 0, ticks - tick_base)
  endtask
  task tally_and_finish;
    if (miscompares == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Cuts a hang short
  initial
  begin
    #50000;
    miscompares++;
    tally_and_finish;
  end
  initial
  begin
    idle(3);
    reset = 1'b0;
    t_reset;
    t_unmapped;
    t_acquire;
    t_post;
    t_pre(MODE_PRE);
    t_delay;
    t_pre(MODE_MIDDLE);
    t_external;
    t_illegal;
    tally_and_finish;
  end
endmodule // acq_fifo_clock_control_test
